// File: rtl/adc_control_registers_regs.vh
// register map, field layout, reset values and timing counts of the converter control block
`ifndef ADC_CONTROL_REGISTERS_REGS_VH
`define ADC_CONTROL_REGISTERS_REGS_VH

// register indices; byte address is four times the index
`define IDX_STATUS_CONTROL 10'h057
`define IDX_CLOCK_CONTROL  10'h058
`define IDX_RESULT_HIGH_0  10'h059
`define IDX_RESULT_LOW_0   10'h05a
`define IDX_SCAN_RESULT_1  10'h05b
`define IDX_SCAN_RESULT_2  10'h05c
`define IDX_SCAN_RESULT_3  10'h05d
`define IDX_SCAN_CONTROL   10'h05e

// status/control fields
`define SC_DONE_BIT   7
`define SC_IRQEN_BIT  6
`define SC_REPEAT_BIT 5
`define SC_SEL_MSB    4
`define SC_SEL_LSB    0

// clock control fields
`define CC_PRE_MSB    7
`define CC_PRE_LSB    5
`define CC_SRC_BIT    4
`define CC_JUST_MSB   3
`define CC_JUST_LSB   2

// scan control fields
`define SCN_LAST_MSB  1
`define SCN_LAST_LSB  0
`define SCN_EN_BIT    2

// reset values
`define SEL_RESET     5'h1f
`define PRE_RESET     3'h0
`define SRC_RESET     1'b0
`define JUST_RESET    2'h1

// input select codes
`define SEL_VREFH     5'h1d
`define SEL_POWERDOWN 5'h1f

// justification codes
`define JUST_TRUNC8   2'h0
`define JUST_RIGHT    2'h1
`define JUST_LEFT     2'h2
`define JUST_LSIGN    2'h3

// converter clock cycles per conversion after the first aligning edge
`define CONV_CYCLES   5'h10

// bus responses
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2

`endif

// File: rtl/adc_control_registers.v
// control and status logic of a 10-bit converter behind an axi4-lite register slave
`timescale 1ns/10ps
`include "adc_control_registers_regs.vh"

module adc_control_registers #(
  parameter ADDR_W = 12
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // axi4-lite write address and data
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  // axi4-lite write response
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  // axi4-lite read
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  // clock source and analog core
  input  wire              crystalTick,
  input  wire [9:0]        convResult,
  output reg               convStart,
  output reg               convBusy,
  output reg               adcClkEn,
  output reg  [4:0]        analogSel,
  output reg               analogPowerDown,
  // interrupt request
  output reg               convIrq
);

  // sequencer states
  localparam ST_IDLE = 2'b00;
  localparam ST_SYNC = 2'b01;
  localparam ST_RUN  = 2'b10;

  // ************************************************************
  // register state
  // ************************************************************
  reg        doneFlag_r;
  reg        irqEn_r;
  reg        repeatConv_r;
  reg  [4:0] inputSel_r;
  reg  [2:0] prescale_r;
  reg        clkSource_r;
  reg  [1:0] justify_r;
  reg  [1:0] scanLast_r;
  reg        scanEn_r;
  reg  [7:0] resHigh0_r;
  reg  [7:0] resLow_r [0:3];
  reg        lowLocked_r;
  reg  [1:0] scanCnt_r;
  reg  [1:0] state_r;
  reg  [1:0] state_nxt;
  reg  [4:0] cycCnt_r;
  reg  [3:0] presCnt_r;
  reg  [ADDR_W-1:0] awAddr_r;
  reg               awHeld_r;
  reg  [31:0]       wData_r;
  reg  [3:0]        wStrb_r;
  reg               wHeld_r;

  // ************************************************************
  // bus decode
  // ************************************************************
  wire [9:0] wrIdx   = awAddr_r[11:2];
  wire [9:0] rdIdx   = s_axi_araddr[11:2];
  wire       wrFire  = awHeld_r & wHeld_r & ~s_axi_bvalid;
  wire       rdFire  = s_axi_arvalid & s_axi_arready;
  wire       wrLane  = wrFire & wStrb_r[0];
  wire       wrStat  = wrLane & (wrIdx == `IDX_STATUS_CONTROL);
  wire       wrClk   = wrLane & (wrIdx == `IDX_CLOCK_CONTROL);
  wire       wrScan  = wrLane & (wrIdx == `IDX_SCAN_CONTROL);
  wire       rdHigh0 = rdFire & (rdIdx == `IDX_RESULT_HIGH_0);
  wire       rdLow0  = rdFire & (rdIdx == `IDX_RESULT_LOW_0);
  wire       rdLowAny = rdFire & (rdIdx >= `IDX_RESULT_LOW_0) & (rdIdx <= `IDX_SCAN_RESULT_3);
  wire       wrMapped = (wrIdx >= `IDX_STATUS_CONTROL) & (wrIdx <= `IDX_SCAN_CONTROL);
  wire       rdMapped = (rdIdx >= `IDX_STATUS_CONTROL) & (rdIdx <= `IDX_SCAN_CONTROL);
  wire [4:0] newSel   = wData_r[`SC_SEL_MSB:`SC_SEL_LSB];
  wire       newSelOn = (newSel != `SEL_POWERDOWN);

  // ************************************************************
  // converter clock prescaler
  // ************************************************************
  // bus clock is clk itself, crystal arrives as an enable pulse
  wire       srcTick = clkSource_r ? 1'b1 : crystalTick;
  reg  [3:0] divMask;
  always @*
  begin
    case (prescale_r)
      3'h0:    divMask = 4'h0;
      3'h1:    divMask = 4'h1;
      3'h2:    divMask = 4'h3;
      3'h3:    divMask = 4'h7;
      default: divMask = 4'hf;
    endcase
  end
  // masked compare so a lowered prescaler never waits for the counter to wrap
  wire adcTick = srcTick & ((presCnt_r & divMask) == divMask);

  // free-running divider; the start lands anywhere in a converter cycle
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      presCnt_r <= 4'h0;
    else if (srcTick)
      presCnt_r <= adcTick ? 4'h0 : presCnt_r + 4'h1;
  end

  // ************************************************************
  // conversion sequencer
  // ************************************************************
  wire powerDown = (inputSel_r == `SEL_POWERDOWN);
  wire convDone  = (state_r == ST_RUN) & adcTick & (cycCnt_r == `CONV_CYCLES - 5'h1);
  wire scanMore  = scanEn_r & (scanCnt_r != scanLast_r);

  // next state: start on write, align on first tick, count the rest
  always @*
  begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: state_nxt = ST_IDLE;
      ST_SYNC: if (adcTick) state_nxt = ST_RUN;
      ST_RUN:
        if (convDone)
          state_nxt = (scanMore | (repeatConv_r & ~scanEn_r)) ? ST_RUN : ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
    if (wrStat)
      state_nxt = newSelOn ? ST_SYNC : ST_IDLE;
    else if (powerDown)
      state_nxt = ST_IDLE;
  end

  // state, cycle count and scan counter
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_r   <= ST_IDLE;
      cycCnt_r  <= 5'h0;
      scanCnt_r <= 2'h0;
    end
    else
    begin
      state_r <= state_nxt;
      if (state_r != ST_RUN || convDone)
        cycCnt_r <= 5'h0;
      else if (adcTick)
        cycCnt_r <= cycCnt_r + 5'h1;
      if (wrStat)
        scanCnt_r <= 2'h0;
      else if (convDone && scanMore)
        scanCnt_r <= scanCnt_r + 2'h1;
    end
  end

  // ************************************************************
  // result formatting and storage
  // ************************************************************
  reg [7:0] fmtHigh;
  reg [7:0] fmtLow;
  always @*
  begin
    case (justify_r)
      `JUST_TRUNC8:
      begin
        fmtHigh = 8'h00;
        fmtLow  = convResult[9:2];
      end
      `JUST_RIGHT:
      begin
        fmtHigh = {6'h00, convResult[9:8]};
        fmtLow  = convResult[7:0];
      end
      `JUST_LEFT:
      begin
        fmtHigh = convResult[9:2];
        fmtLow  = {convResult[1:0], 6'h00};
      end
      default:
      begin
        fmtHigh = {~convResult[9], convResult[8:2]};
        fmtLow  = {convResult[1:0], 6'h00};
      end
    endcase
  end

  wire tenBit   = (justify_r != `JUST_TRUNC8);
  // a held high byte blocks the pair; scan entries hold truncated data only
  wire store0   = convDone & ~(tenBit & lowLocked_r) & ~(scanEn_r & (scanCnt_r != 2'h0));

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      resHigh0_r <= 8'h00;
    else if (store0)
      resHigh0_r <= scanEn_r ? 8'h00 : fmtHigh;
  end

  // one low register per scan entry
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1)
    begin : gLow
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
          resLow_r[gi] <= 8'h00;
        else if (gi == 0 && store0)
          resLow_r[gi] <= scanEn_r ? convResult[9:2] : fmtLow;
        else if (gi != 0 && convDone && scanEn_r && scanCnt_r == gi)
          resLow_r[gi] <= convResult[9:2];
      end
    end
  endgenerate

  // high byte read in a ten-bit justification freezes the low byte; low read or status/control or clock control write frees it
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      lowLocked_r <= 1'b0;
    else if (rdLow0 || wrStat || wrClk)
      lowLocked_r <= 1'b0;
    else if (rdHigh0 && tenBit)
      lowLocked_r <= 1'b1;
  end

  // ************************************************************
  // control registers, done flag and interrupt
  // ************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irqEn_r      <= 1'b0;
      repeatConv_r <= 1'b0;
      inputSel_r   <= `SEL_RESET;
      prescale_r   <= `PRE_RESET;
      clkSource_r  <= `SRC_RESET;
      justify_r    <= `JUST_RESET;
      scanLast_r   <= 2'h0;
      scanEn_r     <= 1'b0;
      doneFlag_r   <= 1'b0;
      convIrq      <= 1'b0;
    end
    else
    begin
      if (wrStat)
      begin
        irqEn_r      <= wData_r[`SC_IRQEN_BIT];
        repeatConv_r <= wData_r[`SC_REPEAT_BIT];
        inputSel_r   <= newSel;
      end
      if (wrClk)
      begin
        prescale_r  <= wData_r[`CC_PRE_MSB:`CC_PRE_LSB];
        clkSource_r <= wData_r[`CC_SRC_BIT];
        justify_r   <= wData_r[`CC_JUST_MSB:`CC_JUST_LSB];
      end
      if (wrScan)
      begin
        scanLast_r <= wData_r[`SCN_LAST_MSB:`SCN_LAST_LSB];
        scanEn_r   <= wData_r[`SCN_EN_BIT];
      end
      // set wins over a clear in the same cycle
      if (convDone && !irqEn_r)
        doneFlag_r <= 1'b1;
      else if (wrStat || wrClk || rdLowAny)
        doneFlag_r <= 1'b0;
      if (convDone && irqEn_r)
        convIrq <= 1'b1;
      else if (rdHigh0 || rdLow0 || wrStat)
        convIrq <= 1'b0;
    end
  end

  // ************************************************************
  // analog core outputs
  // ************************************************************
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      convStart       <= 1'b0;
      convBusy        <= 1'b0;
      adcClkEn        <= 1'b0;
      analogSel       <= `SEL_RESET;
      analogPowerDown <= 1'b1;
    end
    else
    begin
      convStart       <= wrStat & newSelOn;
      convBusy        <= (state_nxt != ST_IDLE);
      adcClkEn        <= adcTick;
      // scan counter or select field steers the mux; 11101 is the reference
      analogSel       <= scanEn_r ? {3'h0, scanCnt_r} : inputSel_r;
      // follows the write at once so a start never meets a powered-down core
      analogPowerDown <= wrStat ? ~newSelOn : powerDown;
    end
  end

  // ************************************************************
  // axi4-lite slave
  // ************************************************************
  reg [7:0] rdByte;
  always @*
  begin
    case (rdIdx)
      `IDX_STATUS_CONTROL: rdByte = {doneFlag_r & ~irqEn_r, irqEn_r, repeatConv_r, inputSel_r};
      `IDX_CLOCK_CONTROL:  rdByte = {prescale_r, clkSource_r, justify_r, 2'h0};
      `IDX_RESULT_HIGH_0:  rdByte = resHigh0_r;
      `IDX_RESULT_LOW_0:   rdByte = resLow_r[0];
      `IDX_SCAN_RESULT_1:  rdByte = resLow_r[1];
      `IDX_SCAN_RESULT_2:  rdByte = resLow_r[2];
      `IDX_SCAN_RESULT_3:  rdByte = resLow_r[3];
      `IDX_SCAN_CONTROL:   rdByte = {5'h00, scanEn_r, scanLast_r};
      default:             rdByte = 8'h00;
    endcase
  end

  // address and data are held independently, the write fires once both are in
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
      awAddr_r      <= {ADDR_W{1'b0}};
      awHeld_r      <= 1'b0;
      wData_r       <= 32'h00000000;
      wStrb_r       <= 4'h0;
      wHeld_r       <= 1'b0;
    end
    else
    begin
      s_axi_awready <= s_axi_awvalid & ~s_axi_awready & ~awHeld_r;
      s_axi_wready  <= s_axi_wvalid & ~s_axi_wready & ~wHeld_r;
      if (s_axi_awvalid && s_axi_awready)
      begin
        awAddr_r <= s_axi_awaddr;
        awHeld_r <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        wData_r <= s_axi_wdata;
        wStrb_r <= s_axi_wstrb;
        wHeld_r <= 1'b1;
      end
      if (wrFire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        awHeld_r     <= 1'b0;
        wHeld_r      <= 1'b0;
      end
      s_axi_arready <= s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
      if (rdFire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, rdByte};
        s_axi_rresp  <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

endmodule // adc_control_registers

// File: test/adc_control_registers_assertions.sv
// assertion checker for the converter control block
`timescale 1ns/10ps
module adc_control_registers_assertions (
  // clock and reset
  input wire        clk,
  input wire        rst_n,
  // register bus
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0]  s_axi_rresp,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  // converter side
  input wire        convStart,
  input wire        convBusy,
  input wire        analogPowerDown,
  input wire        convIrq
);
  // ********************************
  // properties
  // ********************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // bus answers and holding
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rdata_byte: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0
    && (s_axi_rresp == 2'h0 || s_axi_rdata == 32'h0)) else $error("read data malformed");
  // conversion sequencing
  a_start_pulse: assert property (convStart |=> !convStart)
    else $error("start pulse longer than one cycle");
  a_start_busy: assert property (convStart |=> convBusy [*3])
    else $error("conversion ended too soon");
  a_start_powered: assert property (convStart |-> !analogPowerDown)
    else $error("start while powered down");
  a_irq_drop: assert property ($fell(convIrq) |-> s_axi_rvalid || s_axi_bvalid)
    else $error("interrupt dropped without cause");

  // main scenarios
  c_irq: cover property ($rose(convIrq));
  c_start: cover property (convStart);
  c_slverr: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // adc_control_registers_assertions

bind adc_control_registers adc_control_registers_assertions u_checker (
  .clk(clk), .rst_n(rst_n), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .convStart(convStart),
  .convBusy(convBusy), .analogPowerDown(analogPowerDown), .convIrq(convIrq)
);

// File: test/adc_control_registers_bench.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
`include "adc_control_registers_regs.vh"
module adc_control_registers_bench;
  // ********************************
  // stimulus, outputs and tables
  // ********************************
  logic        clk = 0, rst_n = 0, crystalTick = 0;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [11:0] awAddr = 0, arAddr = 0;
  logic [31:0] wData = 0;
  logic [9:0]  convResult = 0;
  logic        awReady, wReady, bValid, arReady, rValid, convBusy, analogPowerDown, convIrq;
  logic        adcClkEn;
  logic [1:0]  bResp, rResp;
  logic [31:0] rData;
  logic [4:0]  analogSel;
  int          errors = 0, checked = 0, cycles = 0;
  // write flag, index, value, response
  logic [20:0] rows [20] = '{{1'b0, `IDX_STATUS_CONTROL, 8'h1f, 2'h0},
    {1'b0, `IDX_CLOCK_CONTROL, 8'h04, 2'h0}, {1'b0, `IDX_RESULT_HIGH_0, 8'h00, 2'h0},
    {1'b0, `IDX_RESULT_LOW_0, 8'h00, 2'h0}, {1'b0, `IDX_SCAN_RESULT_1, 8'h00, 2'h0},
    {1'b0, `IDX_SCAN_RESULT_2, 8'h00, 2'h0}, {1'b0, `IDX_SCAN_RESULT_3, 8'h00, 2'h0},
    {1'b0, `IDX_SCAN_CONTROL, 8'h00, 2'h0}, {1'b0, 10'h056, 8'h00, 2'h2},
    {1'b1, 10'h05f, 8'h00, 2'h2}, {1'b1, `IDX_RESULT_HIGH_0, 8'hff, 2'h0},
    {1'b0, `IDX_RESULT_HIGH_0, 8'h00, 2'h0}, {1'b1, `IDX_STATUS_CONTROL, 8'hdf, 2'h0},
    {1'b0, `IDX_STATUS_CONTROL, 8'h5f, 2'h0}, {1'b1, `IDX_CLOCK_CONTROL, 8'hf4, 2'h0},
    {1'b0, `IDX_CLOCK_CONTROL, 8'hf4, 2'h0}, {1'b1, `IDX_SCAN_CONTROL, 8'h07, 2'h0},
    {1'b0, `IDX_SCAN_CONTROL, 8'h07, 2'h0}, {1'b1, `IDX_SCAN_CONTROL, 8'h00, 2'h0},
    {1'b1, `IDX_STATUS_CONTROL, 8'h1f, 2'h0}};
  logic [4:0]  sel [4] = '{5'h00, 5'h07, `SEL_VREFH, 5'h05};
  logic [7:0]  hi [4] = '{8'h00, 8'h02, 8'hb5, 8'h35};
  logic [7:0]  lo [4] = '{8'hb5, 8'hd6, 8'h80, 8'h80};
  // clock setting, cycles still busy, cycles until idle
  logic [31:0] spans [6] = '{{8'h10, 12'd12, 12'd24}, {8'h30, 12'd27, 12'd42},
    {8'h50, 12'd58, 12'd76}, {8'h70, 12'd120, 12'd144}, {8'hd0, 12'd250, 12'd280},
    {8'h00, 12'd27, 12'd42}};

  adc_control_registers i_dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
    .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
    .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .crystalTick(crystalTick), .convResult(convResult), .convStart(), .convBusy(convBusy),
    .adcClkEn(adcClkEn), .analogSel(analogSel), .analogPowerDown(analogPowerDown),
    .convIrq(convIrq)
  );

  // ********************************
  // clocks, timeout and bus tasks
  // ********************************
  always #4 clk = ~clk;
  // crystal tick every other cycle
  always @(posedge clk) crystalTick <= ~crystalTick & rst_n;
  // hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      errors++;
      tally_and_finish;
    end
  end

  task tally_and_finish;
  begin
    if (errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  end
  endtask

  task chk(input [31:0] got, input [31:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  end
  endtask

  task wr(input [9:0] idx, input [7:0] d, input [1:0] er);
  begin
    awAddr <= {idx, 2'h0};
    wData <= {24'h0, d};
    awValid <= 1;
    wValid <= 1;
    fork
      begin
        @(posedge clk);
        while (!awReady) @(posedge clk);
        awValid <= 0;
      end
      begin
        @(posedge clk);
        while (!wReady) @(posedge clk);
        wValid <= 0;
      end
    join
    bReady <= 1;
    @(posedge clk);
    while (!bValid) @(posedge clk);
    bReady <= 0;
    chk(bResp, er);
  end
  endtask

  task rd(input [9:0] idx, input [7:0] e, input [1:0] er);
  begin
    arAddr <= {idx, 2'h0};
    arValid <= 1;
    @(posedge clk);
    while (!arReady) @(posedge clk);
    arValid <= 0;
    rReady <= 1;
    @(posedge clk);
    while (!rValid) @(posedge clk);
    rReady <= 0;
    chk(rData, {24'h0, e});
    chk(rResp, er);
  end
  endtask

  task idle;
  begin
    repeat (3) @(posedge clk);
    while (convBusy) @(posedge clk);
    repeat (2) @(posedge clk);
  end
  endtask

  // ********************************
  // main sequence
  // ********************************
  initial
  begin
    repeat (12) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    foreach (rows[i])
      if (rows[i][20]) wr(rows[i][19:10], rows[i][9:2], rows[i][1:0]);
      else rd(rows[i][19:10], rows[i][9:2], rows[i][1:0]);
    // every justification with a routed input each
    convResult <= 10'h2d6;
    for (int j = 0; j < 4; j++)
    begin
      wr(`IDX_CLOCK_CONTROL, {4'h1, j[1:0], 2'h0}, 2'h0);
      wr(`IDX_STATUS_CONTROL, {3'h0, sel[j]}, 2'h0);
      idle;
      chk(analogSel, sel[j]);
      rd(`IDX_STATUS_CONTROL, {3'h4, sel[j]}, 2'h0);
      rd(`IDX_RESULT_HIGH_0, hi[j], 2'h0);
      rd(`IDX_RESULT_LOW_0, lo[j], 2'h0);
      rd(`IDX_STATUS_CONTROL, {3'h0, sel[j]}, 2'h0);
    end
    // continuous run with the low byte frozen
    wr(`IDX_CLOCK_CONTROL, 8'h14, 2'h0);
    wr(`IDX_STATUS_CONTROL, 8'h20, 2'h0);
    repeat (40) @(posedge clk);
    rd(`IDX_RESULT_HIGH_0, 8'h02, 2'h0);
    convResult <= 10'h155;
    repeat (60) @(posedge clk);
    chk(convBusy, 1);
    rd(`IDX_RESULT_LOW_0, 8'hd6, 2'h0);
    repeat (40) @(posedge clk);
    rd(`IDX_RESULT_HIGH_0, 8'h01, 2'h0);
    rd(`IDX_RESULT_LOW_0, 8'h55, 2'h0);
    wr(`IDX_STATUS_CONTROL, 8'h1f, 2'h0);
    chk(analogPowerDown, 1);
    repeat (20) @(posedge clk);
    chk(convBusy, 0);
    chk(analogSel, `SEL_POWERDOWN);
    // interrupt raised, read clears, write clears
    wr(`IDX_STATUS_CONTROL, 8'h40, 2'h0);
    idle;
    chk(convIrq, 1);
    rd(`IDX_STATUS_CONTROL, 8'h40, 2'h0);
    rd(`IDX_RESULT_LOW_0, 8'h55, 2'h0);
    chk(convIrq, 0);
    wr(`IDX_STATUS_CONTROL, 8'h40, 2'h0);
    idle;
    wr(`IDX_STATUS_CONTROL, 8'h1f, 2'h0);
    chk(convIrq, 0);
    // clock write clears the done flag
    wr(`IDX_STATUS_CONTROL, 8'h00, 2'h0);
    idle;
    wr(`IDX_CLOCK_CONTROL, 8'h14, 2'h0);
    rd(`IDX_STATUS_CONTROL, 8'h00, 2'h0);
    // conversion length for each source and divider
    foreach (spans[k])
    begin
      wr(`IDX_CLOCK_CONTROL, spans[k][31:24], 2'h0);
      wr(`IDX_STATUS_CONTROL, 8'h00, 2'h0);
      repeat (spans[k][23:12]) @(posedge clk);
      chk(convBusy, 1);
      repeat (spans[k][11:0] - spans[k][23:12]) @(posedge clk);
      chk(convBusy, 0);
    end
    // two-channel scan stops after the last channel
    wr(`IDX_CLOCK_CONTROL, 8'h10, 2'h0);
    wr(`IDX_SCAN_CONTROL, 8'h05, 2'h0);
    chk(adcClkEn, 1);
    wr(`IDX_STATUS_CONTROL, 8'h00, 2'h0);
    idle;
    idle;
    rd(`IDX_SCAN_RESULT_1, 8'h55, 2'h0);
    rd(`IDX_SCAN_RESULT_2, 8'h00, 2'h0);
    wr(`IDX_SCAN_CONTROL, 8'h00, 2'h0);
    // reset in mid-run
    wr(`IDX_STATUS_CONTROL, 8'h60, 2'h0);
    repeat (30) @(posedge clk);
    rst_n <= 0;
    repeat (3) @(posedge clk);
    rst_n <= 1;
    @(posedge clk);
    chk(convIrq, 0);
    rd(`IDX_STATUS_CONTROL, 8'h1f, 2'h0);
    rd(`IDX_CLOCK_CONTROL, 8'h04, 2'h0);
    tally_and_finish;
  end
endmodule // adc_control_registers_bench
